// ==== include/dvb_consts.svh ====
// constants for the divider buzzer output block
// Behaviour
// - The two-bit frequency select picks gear clock divided by 2^12, 2^11, 2^10 or 2^9, or low-frequency clock divided by 2^5, 2^4 or 2^3 with code 11 reserved.
// - With enable set the active-low output pin carries the selected rectangular wave at about half duty.
// - With enable clear the output pin stays high and produces no pulses.
// - Entering stop, idle_zero_mode or sleep_zero_mode mode clears the enable bit, forcing the pin high.
// - The frequency select keeps its value across that automatic enable clear.
// - Control bits 7 down to 3 always read as zero.
// - The prescaler runs whatever the enable, so the first period after enabling may be short.
// - An enable clear by low-power entry cuts the running period short.
// - With the low-frequency source in normal or idle1/2 modes the output may jitter from clock synchronisation.
// - During a normal/slow mode switch the output frequency may deviate while clocks resynchronise.
`ifndef DVB_CONSTS_SVH
`define DVB_CONSTS_SVH
`define DVB_CTRL_OFFSET   8'h38
`define DVB_CTRL_RESET    8'h00
`define DVB_EN_BIT        2
`define DVB_SEL_LSB       0
`define DVB_GEAR_TAP_BASE 8
`define DVB_LF_TAP_BASE   2
`endif

// ==== include/dvb_pkg.sv ====
// types for the divider buzzer output block
package dvb_pkg;
    typedef struct packed {
        logic       enable;
        logic [1:0] sel;
    } dvb_ctrl_t;

    typedef struct packed {
        logic stop_entry;
        logic idle_zero_mode_entry;
        logic sleep_zero_mode_entry;
    } dvb_lp_entry_t;

    typedef enum logic [1:0] {
        DVB_SRC_GEAR,
        DVB_SRC_LF
    } dvb_src_t;
endpackage : dvb_pkg

// ==== verilog/dvb_prescaler.sv ====
// free-running prescaler counting on a one-cycle tick
`timescale 1ns/1ns
`default_nettype none
module dvb_prescaler
#(
    parameter int WIDTH = 13
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             tick_i,
    output logic      [WIDTH-1:0] count_o
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;

    initial
    begin
        if (WIDTH < 13)
        begin
            $error("prescaler too narrow for the gear taps");
        end
    end

    // runs regardless of the enable
    always_comb
    begin
        cnt_d = cnt_q;
        if (tick_i)
        begin
            cnt_d = cnt_q + WIDTH'(1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    assign count_o = cnt_q;
endmodule : dvb_prescaler
`default_nettype wire

// ==== verilog/dvb_top.sv ====
// divider output unit: control register, clock source choice and output pin
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "dvb_consts.svh"
module dvb_top
    import dvb_pkg::*;
#(
    parameter int GEAR_DIV = 1
)
(
    // clock and reset
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    // register port
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    // system mode state
    input  wire logic       LOW_FREQ_SOURCE_SELECT_I,
    input  wire logic       SLOW_MODE_I,
    input  wire logic       STOP_ENTRY_I,
    input  wire logic       IDLE_ZERO_ENTRY_I,
    input  wire logic       SLEEP_ZERO_ENTRY_I,
    // low-frequency clock arriving as a pin
    input  wire logic       LOW_FREQUENCY_CLOCK_I,
    // output pin, active low
    output logic            DIVIDER_OUTPUT_PIN_N_O
);
    initial
    begin
        if (GEAR_DIV < 1 || GEAR_DIV > 65536)
        begin
            $error("gear divide must lie between 1 and 65536");
        end
    end

    // pin synchronisers
    logic [1:0] lf_sync_q;
    logic       lf_prev_q;
    logic [1:0] lfsel_sync_q;
    logic [1:0] slow_sync_q;

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            lf_sync_q    <= 2'h0;
            lf_prev_q    <= 1'b0;
            lfsel_sync_q <= 2'h0;
            slow_sync_q  <= 2'h0;
        end
        else
        begin
            lf_sync_q    <= {lf_sync_q[0], LOW_FREQUENCY_CLOCK_I};
            lf_prev_q    <= lf_sync_q[1];
            lfsel_sync_q <= {lfsel_sync_q[0], LOW_FREQ_SOURCE_SELECT_I};
            slow_sync_q  <= {slow_sync_q[0], SLOW_MODE_I};
        end
    end

    // resampling the slow clock costs up to one cycle of jitter
    logic lf_tick;
    assign lf_tick = lf_sync_q[1] & ~lf_prev_q;

    // gear clock enable from a divider of the system clock
    logic [15:0] gdiv_q;
    logic [15:0] gdiv_d;
    logic        gear_tick;

    always_comb
    begin
        gdiv_d = gdiv_q + 16'h0001;
        if (gdiv_q == 16'(GEAR_DIV - 1))
        begin
            gdiv_d = 16'h0000;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            gdiv_q <= 16'h0000;
        end
        else
        begin
            gdiv_q <= gdiv_d;
        end
    end

    assign gear_tick = (gdiv_q == 16'(GEAR_DIV - 1));

    // source choice: slow modes or the select bit take the low-frequency clock
    dvb_src_t src;
    assign src = (slow_sync_q[1] | lfsel_sync_q[1]) ? DVB_SRC_LF : DVB_SRC_GEAR;

    logic [12:0] gear_cnt;
    logic [12:0] lf_cnt;

    dvb_prescaler #(.WIDTH(13)) u_gear_pre
    (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .tick_i  (gear_tick),
        .count_o (gear_cnt)
    );

    dvb_prescaler #(.WIDTH(13)) u_lf_pre
    (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .tick_i  (lf_tick),
        .count_o (lf_cnt)
    );

    // control register
    dvb_ctrl_t     ctrl_q;
    dvb_ctrl_t     ctrl_d;
    dvb_lp_entry_t lp;
    logic          ctrl_wr;
    logic          lp_entry;
    logic [7:0]    rdata_q;
    logic [7:0]    rdata_d;

    assign lp       = '{stop_entry: STOP_ENTRY_I, idle_zero_mode_entry: IDLE_ZERO_ENTRY_I,
                        sleep_zero_mode_entry: SLEEP_ZERO_ENTRY_I};
    assign lp_entry = lp.stop_entry | lp.idle_zero_mode_entry | lp.sleep_zero_mode_entry;
    assign ctrl_wr  = WR_I && (ADDR_I == `DVB_CTRL_OFFSET);

    always_comb
    begin
        ctrl_d = ctrl_q;
        if (ctrl_wr)
        begin
            ctrl_d.enable = WDATA_I[`DVB_EN_BIT];
            ctrl_d.sel    = WDATA_I[`DVB_SEL_LSB +: 2];
        end
        if (lp_entry)
        begin
            ctrl_d.enable = 1'b0;
            // select is left as it was
        end
        rdata_d = 8'h00;
        if (RD_I && (ADDR_I == `DVB_CTRL_OFFSET))
        begin
            // upper bits stay zero
            rdata_d = {5'h00, ctrl_q.enable, ctrl_q.sel};
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ctrl_q  <= dvb_ctrl_t'(3'(`DVB_CTRL_RESET));
            rdata_q <= 8'h00;
        end
        else
        begin
            ctrl_q  <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    assign RDATA_O = rdata_q;

    // tap choice; the lf reserved code reuses the highest rate, the same tap as code 10
    logic tap;
    always_comb
    begin
        tap = 1'b0;
        if (src == DVB_SRC_GEAR)
        begin
            tap = gear_cnt[`DVB_GEAR_TAP_BASE + 3 - 32'(ctrl_q.sel)];
        end
        else if (ctrl_q.sel == 2'b11)
        begin
            tap = lf_cnt[`DVB_LF_TAP_BASE];
        end
        else
        begin
            tap = lf_cnt[`DVB_LF_TAP_BASE + 2 - 32'(ctrl_q.sel)];
        end
    end

    // pin high while disabled, tap drives it when enabled
    // an enable clear ends the period at once
    logic pin_n_q;
    logic pin_n_d;
    always_comb
    begin
        pin_n_d = ctrl_d.enable ? ~tap : 1'b1;
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            pin_n_q <= 1'b1;
        end
        else
        begin
            pin_n_q <= pin_n_d;
        end
    end

    assign DIVIDER_OUTPUT_PIN_N_O = pin_n_q;

    a_disabled_pin_high : assert property (@(posedge CLK_I) disable iff (RST_I)
        !ctrl_q.enable |-> DIVIDER_OUTPUT_PIN_N_O)
        else $error("pin low while disabled");

    a_lp_clears_enable : assert property (@(posedge CLK_I) disable iff (RST_I)
        lp_entry |=> !ctrl_q.enable && DIVIDER_OUTPUT_PIN_N_O)
        else $error("low-power entry did not clear enable");

    a_lp_keeps_select : assert property (@(posedge CLK_I) disable iff (RST_I)
        lp_entry && !ctrl_wr |=> ctrl_q.sel == $past(ctrl_q.sel))
        else $error("select lost on low-power entry");

    a_read_upper_zero : assert property (@(posedge CLK_I) disable iff (RST_I)
        RD_I |=> RDATA_O[7:3] == 5'h00)
        else $error("upper control bits not zero");

    a_read_returns_ctrl : assert property (@(posedge CLK_I) disable iff (RST_I)
        RD_I && ADDR_I == `DVB_CTRL_OFFSET |=> RDATA_O[2:0] == $past({ctrl_q.enable, ctrl_q.sel}))
        else $error("control readback wrong");

    a_write_enable : assert property (@(posedge CLK_I) disable iff (RST_I)
        ctrl_wr && !lp_entry |=> ctrl_q.enable == $past(WDATA_I[`DVB_EN_BIT]))
        else $error("enable write not taken");

    a_enabled_follows_tap : assert property (@(posedge CLK_I) disable iff (RST_I)
        ctrl_q.enable && $past(ctrl_q.enable) |-> DIVIDER_OUTPUT_PIN_N_O == $past(~tap))
        else $error("pin not following tap");

    a_prescaler_runs : assert property (@(posedge CLK_I) disable iff (RST_I)
        gear_tick |=> gear_cnt == $past(gear_cnt) + 13'h0001)
        else $error("prescaler stalled");

    c_enable_write : cover property (@(posedge CLK_I) disable iff (RST_I)
        ctrl_wr && WDATA_I[`DVB_EN_BIT]);
    c_pin_toggles : cover property (@(posedge CLK_I) disable iff (RST_I)
        ctrl_q.enable && $fell(DIVIDER_OUTPUT_PIN_N_O));
    c_lp_while_on : cover property (@(posedge CLK_I) disable iff (RST_I)
        ctrl_q.enable && lp_entry);
endmodule : dvb_top
`default_nettype wire

// ==== testbench/dvb_buzzer_model.sv ====
// piezo load stand-in that counts drive pulses on the active-low pin
`timescale 1ns/1ns
`default_nettype none
module dvb_buzzer_model
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // pin driving the load
    input  wire logic pin_n_i,
    // falling edges seen so far
    output var  int   pulses_o
);
    logic last_q;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            last_q   <= 1'b1;
            pulses_o <= 0;
        end
        else
        begin
            last_q <= pin_n_i;
            if (last_q && !pin_n_i)
                pulses_o <= pulses_o + 1;
        end
    end
endmodule : dvb_buzzer_model
`default_nettype wire

// ==== testbench/tb_divider_buzzer_output.sv ====
// bench for the divider output unit: register access, rates and mode entry
`timescale 1ns/1ns
`default_nettype none
module tb_divider_buzzer_output;
    logic       clk;
    logic       rst;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       lf_sel;
    logic       slow;
    logic [2:0] lp;
    logic       lf_clk;
    logic       pin_n;
    logic [7:0] lf_cnt;
    logic [7:0] d;
    int         pulses;
    int         err_total;
    int         tests_run;
    int         lo;
    int         hi;
    int         n;
    int         exp_lf[4] = '{160, 640, 160, 320};
    int         sel_lf[4] = '{2, 0, 3, 1};

    dvb_top #(.GEAR_DIV(1)) u_dvb_top (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .LOW_FREQ_SOURCE_SELECT_I(lf_sel), .SLOW_MODE_I(slow), .STOP_ENTRY_I(lp[0]),
        .IDLE_ZERO_ENTRY_I(lp[1]), .SLEEP_ZERO_ENTRY_I(lp[2]),
        .LOW_FREQUENCY_CLOCK_I(lf_clk), .DIVIDER_OUTPUT_PIN_N_O(pin_n));
    dvb_buzzer_model u_dvb_buzzer_model (.clk_i(clk), .rst_i(rst), .pin_n_i(pin_n),
        .pulses_o(pulses));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // slow clock of 40 system cycles
    always @(posedge clk)
    begin
        lf_cnt <= (lf_cnt == 8'h13) ? 8'h00 : lf_cnt + 8'h01;
        if (lf_cnt == 8'h13)
            lf_clk <= ~lf_clk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk_cnt(input string nm, input int e, input int g, input int tol);
        tests_run++;
        if (g < e - tol || g > e + tol)
        begin
            err_total++;
            $display("[FAIL] %s exp %0d got %0d", nm, e, g);
        end
    endtask : chk_cnt

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    // counts cycles until the pin shows v; a hang ends the run
    task automatic wait_pin(input logic v, output int cnt);
        cnt = 0;
        // step off the edge so the pin is read after the design updated it
        #1;
        while (pin_n !== v && cnt < 9000)
        begin
            @(posedge clk);
            #1;
            cnt++;
        end
        if (cnt >= 9000)
        begin
            err_total++;
            $display("[FAIL] pin wait exp %b got %b", v, pin_n);
            end_sim();
        end
    endtask : wait_pin

    // let source and select settle, then start on a true rising edge of the tap
    task automatic measure;
        repeat (4) @(posedge clk);
        wait_pin(1'b1, n);
        wait_pin(1'b0, n);
        wait_pin(1'b1, lo);
        wait_pin(1'b0, hi);
    endtask : measure

    initial
    begin
        {rst, lf_clk} = 2'b10;
        {addr, wdata, lf_cnt} = 24'h00_0000;
        {wr, rd, lf_sel, slow, lp} = 7'h00;
        err_total = 0;
        tests_run = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_reg(8'h38, d);
        chk8("ctrl reset", 8'h00, d);
        chk8("pin idle", 8'h01, {7'h00, pin_n});
        wr_reg(8'h38, 8'hFF);
        rd_reg(8'h38, d);
        chk8("ctrl upper bits", 8'h07, d);
        rd_reg(8'h39, d);
        chk8("unmapped read", 8'h00, d);
        wr_reg(8'h39, 8'h00);
        rd_reg(8'h38, d);
        chk8("unmapped write", 8'h07, d);
        for (int s = 0; s < 4; s++)
        begin
            wr_reg(8'h38, 8'h04 | s[7:0]);
            measure();
            chk_cnt("gear low", 1 << (11 - s), lo, 0);
            chk_cnt("gear high", 1 << (11 - s), hi, 0);
        end
        // prescaler keeps running while off, so re-enabling 768 cycles after the pin rose lands on a tap rise and gives a full 256-cycle low
        wait_pin(1'b1, n);
        wr_reg(8'h38, 8'h03);
        n = pulses;
        repeat (764) @(posedge clk);
        chk_cnt("pulses while off", n, pulses, 0);
        wr_reg(8'h38, 8'h07);
        #1;
        wait_pin(1'b1, lo);
        chk_cnt("first low", 256, lo, 4);
        for (int k = 0; k < 3; k++)
        begin
            wr_reg(8'h38, 8'h05 + k[7:0]);
            repeat (2) @(posedge clk);
            wait_pin(1'b1, n);
            wait_pin(1'b0, n);
            repeat (5) @(posedge clk);
            lp <= 3'b001 << k;
            @(posedge clk);
            lp <= 3'b000;
            #1 chk8("pin after entry", 8'h01, {7'h00, pin_n});
            rd_reg(8'h38, d);
            chk8("ctrl after entry", 8'h01 + k[7:0], d);
        end
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            slow   <= (k == 3);
            lf_sel <= (k != 3);
            wr_reg(8'h38, 8'h04 | sel_lf[k][7:0]);
            measure();
            chk_cnt("slow low", exp_lf[k], lo, 3);
            chk_cnt("slow high", exp_lf[k], hi, 3);
        end
        end_sim();
    end

    initial
    begin
        #300000;
        err_total++;
        end_sim();
    end
endmodule : tb_divider_buzzer_output
`default_nettype wire
